// ==== shared/axis_param_pkg.sv ====
// shared constants for the axis parameter command block
package axis_param_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0C;
  localparam logic [7:0] REG_WINDOW = 8'h10;
  localparam logic [7:0] REG_SETTLE = 8'h14;
  localparam logic [7:0] REG_TIMEOUT = 8'h18;
  localparam logic [7:0] REG_PAR_BASE = 8'h20;
  localparam int ST_IDLE_BIT = 4;
  localparam int ST_CORR_BIT = 5;
  localparam int ST_BKP_BIT = 6;
  localparam int ST_TMO_BIT = 7;
  // ----------------------------------------
  // commands and answers
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_SPAN = 4'h1, CMD_SPEED = 4'h2, CMD_DEADBAND = 4'h3,
    CMD_FF = 4'h4, CMD_PGAIN = 4'h5, CMD_SUMG = 4'h6, CMD_VDAMP = 4'h7, CMD_XDAMP = 4'h8,
    CMD_BACKUP = 4'h9
  } cmd_e;
  typedef enum logic [2:0] {
    RSP_NONE = 3'h0, RSP_OK = 3'h1, RSP_OOR = 3'h2, RSP_JOY_FAIL = 3'h3,
    RSP_STEPPER_NA = 3'h4, RSP_NOT_IDLE = 3'h5, RSP_UNKNOWN = 3'h6
  } rsp_e;
  // ----------------------------------------
  // parameter table: index, limits, reset value
  // ----------------------------------------
  localparam int NPAR = 9;
  localparam int PW = 19;
  localparam logic [3:0] P_SPAN = 4'h0;
  localparam logic [3:0] P_SPEED = 4'h1;
  localparam logic [3:0] P_DEAD = 4'h2;
  localparam logic [3:0] P_FF = 4'h3;
  localparam logic [3:0] P_KPS = 4'h4;
  localparam logic [3:0] P_KPC = 4'h5;
  localparam logic [3:0] P_SUMG = 4'h6;
  localparam logic [3:0] P_VDAMP = 4'h7;
  localparam logic [3:0] P_XDAMP = 4'h8;
  localparam logic [3:0] P_NONE = 4'hF;
  localparam logic [PW-1:0] PAR_MIN [NPAR] = '{19'h00064, 19'h00001, 19'h00001,
    19'h00000, 19'h00000, 19'h00000, 19'h00000, 19'h00000, 19'h00000};
  localparam logic [PW-1:0] PAR_MAX [NPAR] = '{19'h00FFF, 19'h61A80, 19'h00FFF,
    19'h07FFF, 19'h07FFF, 19'h00064, 19'h07FFF, 19'h07FFF, 19'h07FFF};
  localparam logic [PW-1:0] PAR_INIT [NPAR] = '{19'h00140, 19'h02710, 19'h00028,
    19'h00000, 19'h0000A, 19'h00046, 19'h00000, 19'h00000, 19'h00000};
  // ----------------------------------------
  // modes, correction defaults, timing
  // ----------------------------------------
  localparam logic [3:0] MODE_SERVO = 4'h1;
  localparam logic [3:0] MODE_CLSTEP = 4'hE;
  localparam logic [15:0] WINDOW_INIT = 16'h0004;
  localparam logic [15:0] SETTLE_INIT = 16'h000A;
  localparam logic [15:0] TIMEOUT_INIT = 16'h03E8;
  localparam int MS_NS = 1000000;
  localparam int CORE_PERIOD_NS = 5;
  localparam int CYC_PER_MS = MS_NS / CORE_PERIOD_NS;
endpackage : axis_param_pkg

// ==== src/axis_param_ctrl.sv ====
// joystick and loop coefficient command interpreter for one axis
//
// Design decisions made here: strobed register access and the register offsets.
module axis_param_ctrl
  import axis_param_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
)(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_AXIS_IDLE,
  input wire logic [11:0] I_JOY_VALUE,
  output logic O_JOY_ACTIVE,
  output logic O_RSP_VALID,
  output logic [2:0] O_RSP_CODE,
  input wire logic I_CORR_START,
  input wire logic [31:0] I_CMD_POS,
  input wire logic [31:0] I_ACT_POS,
  output logic [31:0] O_CORR_STEP,
  output logic O_CORR_STEP_VALID,
  output logic O_CORR_BUSY,
  output logic O_NV_WRITE,
  output logic [3:0] O_NV_INDEX,
  output logic [31:0] O_NV_DATA
);
  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic [3:0] cmd_index(input cmd_e c, input logic clstep);
    case (c)
      CMD_SPAN: cmd_index = P_SPAN;
      CMD_SPEED: cmd_index = P_SPEED;
      CMD_DEADBAND: cmd_index = P_DEAD;
      CMD_FF: cmd_index = P_FF;
      CMD_PGAIN: cmd_index = clstep ? P_KPC : P_KPS;
      CMD_SUMG: cmd_index = P_SUMG;
      CMD_VDAMP: cmd_index = P_VDAMP;
      CMD_XDAMP: cmd_index = P_XDAMP;
      default: cmd_index = P_NONE;
    endcase
  endfunction : cmd_index

  function automatic logic servo_only(input cmd_e c);
    servo_only = (c == CMD_FF) || (c == CMD_SUMG) || (c == CMD_VDAMP) || (c == CMD_XDAMP);
  endfunction : servo_only

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [PW-1:0] par [NPAR];
  logic [PW-1:0] next_par [NPAR];
  logic [31:0] arg, next_arg;
  logic [3:0] mode, next_mode;
  logic [15:0] window, next_window;
  logic [15:0] settle, next_settle;
  logic [15:0] tmo, next_tmo;
  rsp_e rsp, next_rsp;
  logic next_rsp_valid;
  logic next_joy_active;
  logic [31:0] next_rdata;
  logic bkp_start, bkp_busy, corr_tmo;
  logic stepper, clstep, blocked, cmd_wr;
  cmd_e code;
  logic [3:0] idx;
  logic [PW-1:0] pmax, pmin;

  assign stepper = (mode != MODE_SERVO);
  assign clstep = (mode == MODE_CLSTEP);
  assign blocked = !I_AXIS_IDLE || bkp_busy || O_CORR_BUSY;
  assign cmd_wr = I_WR && (I_ADDR == REG_CMD);
  assign code = cmd_e'(I_WDATA[3:0]);
  assign idx = cmd_index(code, clstep);
  assign pmax = (idx < 4'(NPAR)) ? PAR_MAX[idx] : '0;
  assign pmin = (idx < 4'(NPAR)) ? PAR_MIN[idx] : '0;

  // ----------------------------------------
  // command execution and register writes
  // ----------------------------------------
  always_comb begin
    next_par = par;
    next_arg = arg;
    next_mode = mode;
    next_window = window;
    next_settle = settle;
    next_tmo = tmo;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    bkp_start = 1'b0;
    if (I_WR) begin
      case (I_ADDR)
        REG_ARG: next_arg = I_WDATA;
        REG_MODE: next_mode = I_WDATA[3:0];
        REG_WINDOW: next_window = I_WDATA[15:0];
        REG_SETTLE: next_settle = I_WDATA[15:0];
        REG_TIMEOUT: next_tmo = I_WDATA[15:0];
        REG_CMD: begin
          next_rsp_valid = 1'b1;
          if (blocked) begin
            next_rsp = RSP_NOT_IDLE;
          end else if (code == CMD_BACKUP) begin
            bkp_start = 1'b1;
            next_rsp = RSP_OK;
          end else if (idx == P_NONE) begin
            next_rsp = RSP_UNKNOWN;
          end else if (servo_only(code) && stepper) begin
            next_rsp = RSP_STEPPER_NA;
          end else if (arg > {13'h0000, pmax}) begin
            next_rsp = RSP_OOR;
          end else if (arg < {13'h0000, pmin}) begin
            // a span below the floor is a calibration fault, not a range slip
            next_rsp = (idx == P_SPAN) ? RSP_JOY_FAIL : RSP_OOR;
          end else begin
            next_par[idx] = arg[PW-1:0];
            next_rsp = RSP_OK;
          end
        end
        default: next_rsp = rsp;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NPAR; i++) begin
        par[i] <= PAR_INIT[i];
      end
      arg <= 32'h0000_0000;
      mode <= MODE_SERVO;
      window <= WINDOW_INIT;
      settle <= SETTLE_INIT;
      tmo <= TIMEOUT_INIT;
      rsp <= RSP_NONE;
      O_RSP_VALID <= 1'b0;
    end else begin
      par <= next_par;
      arg <= next_arg;
      mode <= next_mode;
      window <= next_window;
      settle <= next_settle;
      tmo <= next_tmo;
      rsp <= next_rsp;
      O_RSP_VALID <= next_rsp_valid;
    end
  end
  assign O_RSP_CODE = rsp;

  // ----------------------------------------
  // joystick activity and register reads
  // ----------------------------------------
  always_comb begin
    logic [7:0] off;
    off = I_ADDR - REG_PAR_BASE;
    next_joy_active = (I_JOY_VALUE >= par[P_DEAD][11:0]);
    next_rdata = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        REG_ARG: next_rdata = arg;
        REG_STATUS: begin
          next_rdata[2:0] = rsp;
          next_rdata[ST_IDLE_BIT] = I_AXIS_IDLE;
          next_rdata[ST_CORR_BIT] = O_CORR_BUSY;
          next_rdata[ST_BKP_BIT] = bkp_busy;
          next_rdata[ST_TMO_BIT] = corr_tmo;
        end
        REG_MODE: next_rdata = {28'h0000000, mode};
        REG_WINDOW: next_rdata = {16'h0000, window};
        REG_SETTLE: next_rdata = {16'h0000, settle};
        REG_TIMEOUT: next_rdata = {16'h0000, tmo};
        default: begin
          // unmapped addresses read as zero
          if (I_ADDR >= REG_PAR_BASE && off[7:2] < 6'(NPAR) && off[1:0] == 2'h0)
            next_rdata = {13'h0000, par[off[5:2]]};
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_JOY_ACTIVE <= 1'b0;
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_JOY_ACTIVE <= next_joy_active;
      O_RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // backup streamer and stepper correction
  // ----------------------------------------
  nv_backup_seq u_bkp (
    .clk(I_CORE_CLK),
    .rst_n(I_RST_N),
    .i_start(bkp_start),
    .i_par(par),
    .o_busy(bkp_busy),
    .o_nv_write(O_NV_WRITE),
    .o_nv_index(O_NV_INDEX),
    .o_nv_data(O_NV_DATA)
  );

  stepper_correction #(.CYC_MS(CYC_MS)) u_corr (
    .clk(I_CORE_CLK),
    .rst_n(I_RST_N),
    .i_start(I_CORR_START),
    .i_enable(clstep),
    .i_cmd_pos(I_CMD_POS),
    .i_act_pos(I_ACT_POS),
    .i_gain(par[P_KPC][6:0]),
    .i_window(window),
    .i_settle(settle),
    .i_timeout(tmo),
    .o_step(O_CORR_STEP),
    .o_step_valid(O_CORR_STEP_VALID),
    .o_busy(O_CORR_BUSY),
    .o_timed_out(corr_tmo)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  logic go;
  assign go = cmd_wr && !blocked;

  sequence s_backup_cmd;
    go && code == CMD_BACKUP;
  endsequence
  sequence s_nv_burst;
    O_NV_WRITE && O_NV_INDEX == 4'h0 ##1 O_NV_WRITE && O_NV_INDEX == 4'h1;
  endsequence

  a_span_low_fail: assert property (
    go && code == CMD_SPAN && arg < 32'h0000_0064 |=> O_RSP_VALID && rsp == RSP_JOY_FAIL)
    else $error("low span not answered with joystick failure");
  a_span_bounds: assert property (
    par[P_SPAN] <= 19'h00FFF && par[P_SPAN] >= 19'h00064)
    else $error("span left its range");
  a_speed_store: assert property (
    go && code == CMD_SPEED && arg >= 32'h0000_0001 && arg <= 32'h0006_1A80
    |=> par[P_SPEED] == $past(arg[PW-1:0]) && rsp == RSP_OK)
    else $error("speed not stored");
  a_joy_active: assert property (
    ##1 O_JOY_ACTIVE == ($past(I_JOY_VALUE) >= $past(par[P_DEAD][11:0])))
    else $error("joystick activity wrong");
  a_oor_keeps: assert property (
    go && code == CMD_SUMG && !stepper && arg > 32'h0000_7FFF
    |=> rsp == RSP_OOR && par[P_SUMG] == $past(par[P_SUMG]))
    else $error("out of range value stored");
  a_stepper_refuse: assert property (
    go && servo_only(code) && stepper |=> rsp == RSP_STEPPER_NA && $stable(par[P_VDAMP]))
    else $error("servo coefficient taken in stepper mode");
  a_backup_burst: assert property (
    s_backup_cmd |=> ##1 s_nv_burst)
    else $error("backup did not stream parameters");
  a_gain_percent: assert property (
    go && code == CMD_PGAIN && clstep && arg > 32'h0000_0064 |=> rsp == RSP_OOR)
    else $error("correction gain over 100 accepted");
  a_busy_reject: assert property (
    cmd_wr && !I_AXIS_IDLE |=> O_RSP_VALID && rsp == RSP_NOT_IDLE && $stable(par[P_FF]))
    else $error("command accepted during motion");
endmodule : axis_param_ctrl

// ==== src/nv_backup_seq.sv ====
// streams every stored parameter out to nonvolatile storage on request
module nv_backup_seq
  import axis_param_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_start,
  input wire logic [PW-1:0] i_par [NPAR],
  output logic o_busy,
  output logic o_nv_write,
  output logic [3:0] o_nv_index,
  output logic [31:0] o_nv_data
);
  typedef enum logic {B_IDLE = 1'b0, B_SEND = 1'b1} bstate_e;
  bstate_e state, next_state;
  logic [3:0] idx, next_idx;
  logic next_write;
  logic [3:0] next_index;
  logic [31:0] next_data;

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_write = 1'b0;
    next_index = o_nv_index;
    next_data = o_nv_data;
    case (state)
      B_IDLE: begin
        if (i_start) begin
          next_state = B_SEND;
          next_idx = 4'h0;
        end
      end
      B_SEND: begin
        next_write = 1'b1;
        next_index = idx;
        next_data = {13'h0000, i_par[idx]};
        next_idx = idx + 4'h1;
        if (idx == 4'(NPAR - 1)) next_state = B_IDLE;
      end
      default: next_state = B_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= B_IDLE;
      idx <= 4'h0;
      o_nv_write <= 1'b0;
      o_nv_index <= 4'h0;
      o_nv_data <= 32'h0000_0000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      o_nv_write <= next_write;
      o_nv_index <= next_index;
      o_nv_data <= next_data;
    end
  end
  assign o_busy = (state == B_SEND);
endmodule : nv_backup_seq

// ==== src/stepper_correction.sv ====
// iterative position correction for the closed-loop stepper mode
module stepper_correction
  import axis_param_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_start,
  input wire logic i_enable,
  input wire logic signed [31:0] i_cmd_pos,
  input wire logic signed [31:0] i_act_pos,
  input wire logic [6:0] i_gain,
  input wire logic [15:0] i_window,
  input wire logic [15:0] i_settle,
  input wire logic [15:0] i_timeout,
  output logic signed [31:0] o_step,
  output logic o_step_valid,
  output logic o_busy,
  output logic o_timed_out
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_EVAL = 2'b01, C_SETTLE = 2'b10} cstate_e;
  cstate_e state, next_state;
  logic [31:0] div, next_div;
  logic tick;
  logic [15:0] elapsed, next_elapsed, settled, next_settled;
  logic signed [31:0] next_step;
  logic next_valid, next_tmo, next_busy;
  logic signed [32:0] err, mag;
  logic signed [40:0] scaled;

  // ----------------------------------------
  // millisecond enable and step arithmetic
  // ----------------------------------------
  assign tick = (div == 32'(CYC_MS - 1));
  assign err = 33'(i_cmd_pos) - 33'(i_act_pos);
  assign mag = err[32] ? -err : err;
  assign scaled = (41'(err) * $signed({34'h0, i_gain})) / 41'sd100;

  always_comb begin
    next_div = tick ? 32'h0000_0000 : div + 32'h0000_0001;
    next_state = state;
    next_elapsed = tick ? elapsed + 16'h0001 : elapsed;
    next_settled = settled;
    next_step = o_step;
    next_valid = 1'b0;
    next_tmo = o_timed_out;
    case (state)
      C_IDLE: begin
        if (i_start && i_enable) begin
          next_state = C_EVAL;
          next_elapsed = 16'h0000;
          next_tmo = 1'b0;
        end
      end
      C_EVAL: begin
        if (mag <= $signed({17'h00000, i_window})) begin
          next_state = C_IDLE;
        end else if (elapsed >= i_timeout) begin
          next_state = C_IDLE;
          next_tmo = 1'b1;
        end else begin
          // never less than one step, else a small error would stall
          if (scaled == 41'sd0) next_step = err[32] ? -32'sd1 : 32'sd1;
          else next_step = scaled[31:0];
          next_valid = 1'b1;
          next_settled = 16'h0000;
          next_state = C_SETTLE;
        end
      end
      C_SETTLE: begin
        if (tick) begin
          next_settled = settled + 16'h0001;
          if (next_settled >= i_settle) next_state = C_EVAL;
        end
      end
      default: next_state = C_IDLE;
    endcase
    // busy leaves a flop so the top-level output carries no gate
    next_busy = (next_state != C_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= C_IDLE;
      div <= 32'h0000_0000;
      elapsed <= 16'h0000;
      settled <= 16'h0000;
      o_step <= 32'sh0000_0000;
      o_step_valid <= 1'b0;
      o_timed_out <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      elapsed <= next_elapsed;
      settled <= next_settled;
      o_step <= next_step;
      o_step_valid <= next_valid;
      o_timed_out <= next_tmo;
      o_busy <= next_busy;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_step_not_zero: assert property (@(posedge clk) disable iff (!rst_n)
    o_step_valid |-> o_step != 32'sd0)
    else $error("correction step of zero issued");
  a_step_settles: assert property (@(posedge clk) disable iff (!rst_n)
    o_step_valid |-> state == C_SETTLE ##1 !o_step_valid)
    else $error("correction step not followed by settling");
endmodule : stepper_correction

// ==== tb/host_model.sv ====
// host side model: drives the register port with addressed commands
module host_model
  import axis_param_pkg::*;
(
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask : wr_reg

  // released lines flip so a stale value can never look valid
  task automatic idle_bus();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask : idle_bus

  task automatic wr_cfg(input logic [7:0] a, input logic [31:0] d);
    wr_reg(a, d);
    idle_bus();
  endtask : wr_cfg

  // argument first, then the command code, back to back
  task automatic send(input logic [3:0] code, input logic [31:0] arg);
    wr_reg(REG_ARG, arg);
    wr_reg(REG_CMD, {28'h0, code});
    idle_bus();
  endtask : send

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    idle_bus();
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : host_model

// ==== tb/testbench.sv ====
// self-checking bench for the axis parameter command block
module testbench
  import axis_param_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 4;
  localparam int SET_CYC = 10 * CYC;

  logic clk, rst_n, wr, rd, idle, start, joy_act, rsp_valid, step_valid, busy, nv_wr;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, cmd_pos, act_pos, step, nv_data, d;
  logic [11:0] joy;
  logic [2:0] rsp_code;
  logic [3:0] nv_idx;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  logic [31:0] exp_par [9] = '{32'h140, 32'h2710, 32'h28, 32'h0, 32'hA, 32'h46,
    32'h0, 32'h0, 32'h0};
  logic [3:0] t_idx [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
  logic [31:0] t_min [8] = '{32'h64, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] t_max [8] = '{32'hFFF, 32'h61A80, 32'hFFF, 32'h7FFF, 32'h7FFF,
    32'h7FFF, 32'h7FFF, 32'h7FFF};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  axis_param_ctrl #(.CYC_MS(CYC)) DUT (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_AXIS_IDLE(idle), .I_JOY_VALUE(joy),
    .O_JOY_ACTIVE(joy_act), .O_RSP_VALID(rsp_valid), .O_RSP_CODE(rsp_code),
    .I_CORR_START(start), .I_CMD_POS(cmd_pos), .I_ACT_POS(act_pos), .O_CORR_STEP(step),
    .O_CORR_STEP_VALID(step_valid), .O_CORR_BUSY(busy), .O_NV_WRITE(nv_wr),
    .O_NV_INDEX(nv_idx), .O_NV_DATA(nv_data));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ceiling well above the roughly 400 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic do_cmd(input logic [3:0] c, input logic [31:0] a, input logic [2:0] e);
    host.send(c, a);
    #1;
    chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    chk("rsp_code", {29'h0, rsp_code}, {29'h0, e});
  endtask : do_cmd

  task automatic chk_par(input int i);
    host.rd_reg(REG_PAR_BASE + 8'(4 * i), d);
    chk("param", d, exp_par[i]);
  endtask : chk_par

  task automatic wait_step(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (step_valid !== 1'b1 && n < lim);
  endtask : wait_step

  task automatic kick();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask : kick

  task automatic wait_idle(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < lim);
    chk("corr_busy", {31'h0, busy}, 32'h0);
  endtask : wait_idle

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    idle = 1'b1;
    start = 1'b0;
    joy = 12'h000;
    cmd_pos = 32'h0;
    act_pos = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      chk_par(i);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      do_cmd(4'(i + 1), t_max[i], RSP_OK);
      exp_par[t_idx[i]] = t_max[i];
      chk_par(t_idx[i]);
      do_cmd(4'(i + 1), t_max[i] + 32'h1, RSP_OOR);
      chk_par(t_idx[i]);
      if (t_min[i] != 32'h0) begin
        do_cmd(4'(i + 1), t_min[i] - 32'h1, (i == 0) ? RSP_JOY_FAIL : RSP_OOR);
        chk_par(t_idx[i]);
      end
      do_cmd(4'(i + 1), t_min[i], RSP_OK);
      exp_par[t_idx[i]] = t_min[i];
      chk_par(t_idx[i]);
    end
    do_cmd(4'hA, 32'h1, RSP_UNKNOWN);
    $display("test ranges done");
    // profile move: feedforward matches damping, short of full compensation
    do_cmd(4'h7, 32'h12C, RSP_OK);
    do_cmd(4'h4, 32'h12C, RSP_OK);
    exp_par[7] = 32'h12C;
    exp_par[3] = 32'h12C;
    idle <= 1'b0;
    do_cmd(4'h1, 32'h1F4, RSP_NOT_IDLE);
    idle <= 1'b1;
    chk_par(0);
    $display("test idle guard done");
    host.wr_cfg(REG_MODE, 32'hE);
    for (int c = 4; c < 9; c++) begin
      if (c != 5) begin
        do_cmd(4'(c), 32'h1, RSP_STEPPER_NA);
      end
    end
    do_cmd(4'h5, 32'h65, RSP_OOR);
    do_cmd(4'h5, 32'h32, RSP_OK);
    exp_par[5] = 32'h32;
    for (int i = 3; i < 9; i++) begin
      chk_par(i);
    end
    $display("test stepper mode done");
    cmd_pos <= 32'h64;
    kick();
    wait_step(8);
    chk("step", step, 32'h32);
    wait_step(80);
    chk("gap_ok", {31'h0, n >= SET_CYC - CYC && n <= SET_CYC + 2 * CYC}, 32'h1);
    act_pos <= 32'h62;
    wait_idle(80);
    host.wr_cfg(REG_TIMEOUT, 32'h1);
    do_cmd(4'h5, 32'hA, RSP_OK);
    exp_par[5] = 32'hA;
    act_pos <= 32'h5F;
    kick();
    wait_step(8);
    chk("step_min", step, 32'h1);
    wait_idle(120);
    host.rd_reg(REG_STATUS, d);
    chk("timed_out", {31'h0, d[ST_TMO_BIT]}, 32'h1);
    $display("test correction done");
    do_cmd(4'h3, 32'h32, RSP_OK);
    exp_par[2] = 32'h32;
    joy <= 12'h031;
    repeat (2) @(posedge clk);
    #1;
    chk("joy_active", {31'h0, joy_act}, 32'h0);
    joy <= 12'h032;
    repeat (2) @(posedge clk);
    #1;
    chk("joy_active", {31'h0, joy_act}, 32'h1);
    $display("test joystick done");
    do_cmd(4'h9, 32'h0, RSP_OK);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #1;
      chk("nv_write", {31'h0, nv_wr}, 32'h1);
      chk("nv_index", {28'h0, nv_idx}, 32'(i));
      chk("nv_data", nv_data, exp_par[i]);
    end
    $display("test backup done");
    host.wr_cfg(8'hFC, 32'h5A5A);
    host.rd_reg(8'hFC, d);
    chk("unmapped", d, 32'h0);
    $display("test unmapped done");
    print_verdict();
  end
endmodule : testbench
